/* stx_peer.sv */
// remote station model: decodes frames seen on the line
`default_nettype none
module stx_peer (
  // clock and line
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       run_i,
  output logic            xclk_o,
  // expected frame shape
  input  wire logic [3:0] nbits_i,
  input  wire logic       par_i,
  input  wire logic       stop2_i,
  input  wire logic       sync_i,
  input  wire logic [7:0] bit_cyc_i,
  // last frame seen
  output logic      [8:0] data_o,
  output logic            par_o,
  output logic            stop_o,
  output logic     [15:0] cnt_o,
  output logic     [31:0] t_start_o,
  output logic     [31:0] t_prev_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] cyc = 32'h0000_0000;
  logic [8:0]  d;
  logic        p;
  logic        s;
  always @(posedge clk_i) cyc <= cyc + 32'h0000_0001;
  // client clock stands low while run_i is low
  initial begin
    xclk_o = 1'b0;
    forever #62.5 xclk_o = run_i ? ~xclk_o : 1'b0;
  end
  task automatic next_bit();
    if (sync_i) begin
      @(posedge xclk_o);
      @(negedge xclk_o);
    end else begin
      repeat (bit_cyc_i) @(posedge clk_i);
    end
  endtask
  initial begin
    {data_o, par_o, stop_o, cnt_o, t_start_o, t_prev_o} = '0;
    forever begin
      @(negedge line_i);
      t_prev_o = t_start_o;
      t_start_o = cyc;
      d = 9'h000;
      p = 1'b0;
      // async: sample mid-bit, tolerates the odd stretched bit
      if (!sync_i) repeat (bit_cyc_i / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        if (i < nbits_i) begin
          next_bit();
          d[i] = line_i;
        end
      end
      if (par_i) begin
        next_bit();
        p = line_i;
      end
      next_bit();
      s = line_i;
      if (stop2_i) begin
        next_bit();
        s = s & line_i;
      end
      {data_o, par_o, stop_o} = {d, p, s};
      cnt_o++;
    end
  end
endmodule // stx_peer
`default_nettype wire

/* stx_pkg.sv */
// shared constants for the serial transmit framing and rate generator
`default_nettype none
package stx_pkg;
  // register indices on the plain register port
  localparam logic [3:0] STX_REG_BAUD_LO   = 4'h0;
  localparam logic [3:0] STX_REG_BAUD_HI   = 4'h1;
  localparam logic [3:0] STX_REG_FRAME_CFG = 4'h2;
  localparam logic [3:0] STX_REG_EN_CFG    = 4'h3;
  localparam logic [3:0] STX_REG_LOOP_CFG  = 4'h4;
  localparam logic [3:0] STX_REG_TX_LOW    = 4'h5;
  localparam logic [3:0] STX_REG_TX_HIGH   = 4'h6;
  localparam logic [3:0] STX_REG_STATUS    = 4'h7;
  // frame_config_reg fields
  localparam int STX_FC_CHAR_LSB = 0;   // char_width_sel [2:0]
  localparam int STX_FC_PAR_LSB  = 4;   // parity [5:4]
  localparam int STX_FC_STOP_BIT = 3;   // two stop bits
  localparam int STX_FC_MODE_LSB = 6;   // mode [7:6]
  // enable_config_reg fields
  localparam int STX_EC_TXEN   = 6;
  localparam int STX_EC_OPEN_DRAIN_EN   = 3;
  localparam int STX_EC_DBLSPD = 1;
  localparam int STX_EC_RS485  = 0;
  // irq_loop_config_reg fields
  localparam int STX_LC_LOOP   = 3;
  // status fields
  localparam int STX_ST_DONE   = 6;
  localparam int STX_ST_EMPTY  = 5;
  // character widths
  localparam logic [2:0] STX_CW_5  = 3'h0;
  localparam logic [2:0] STX_CW_6  = 3'h1;
  localparam logic [2:0] STX_CW_7  = 3'h2;
  localparam logic [2:0] STX_CW_8  = 3'h3;
  localparam logic [2:0] STX_CW_9L = 3'h6;
  localparam logic [2:0] STX_CW_9H = 3'h7;
  // parity selections
  localparam logic [1:0] STX_PAR_EVEN = 2'h2;
  localparam logic [1:0] STX_PAR_ODD  = 2'h3;
  // modes
  localparam logic [1:0] STX_MODE_ASYNC = 2'h0;
  localparam logic [1:0] STX_MODE_SYNC  = 2'h1;
  // samples per bit
  localparam logic [4:0] STX_S_NORMAL = 5'h10;
  localparam logic [4:0] STX_S_DOUBLE = 5'h08;
  localparam logic [4:0] STX_S_SYNC   = 5'h02;
  localparam int         STX_FRAC_W   = 6;
  // reset values
  localparam logic [15:0] STX_BAUD_RST = 16'h0040;
  localparam logic [7:0]  STX_FC_RST   = 8'h03;
  localparam logic [7:0]  STX_ZERO8    = 8'h00;
  typedef enum logic [1:0] {STX_IDLE, STX_SHIFT} stx_state_type;
endpackage : stx_pkg
`default_nettype wire

/* stx_sva.sv */
// concurrent checks on the transmitter ports
`default_nettype none
module stx_sva
  import stx_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       clk_en_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // line side
  input wire logic       xfer_clock_pin_i,
  input wire logic       tx_pin_i,
  input wire logic       tx_pin_o,
  input wire logic       tx_pin_oe_o,
  input wire logic       tx_override_o,
  input wire logic       line_driver_dir_out_o,
  input wire logic       rx_line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ec_q;
  logic       lb_q;
  logic       wr_ok;
  assign wr_ok = reg_wr_i && clk_en_i;
  // shadow settings: pin rules depend on them
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i)
      ec_q <= STX_ZERO8;
    else if (wr_ok && reg_addr_i == STX_REG_EN_CFG)
      ec_q <= reg_wdata_i;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i)
      lb_q <= 1'b0;
    else if (wr_ok && reg_addr_i == STX_REG_LOOP_CFG)
      lb_q <= reg_wdata_i[STX_LC_LOOP];
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  a_od_drive: assert property (
    ec_q[STX_EC_OPEN_DRAIN_EN] && $past(ec_q[STX_EC_OPEN_DRAIN_EN]) && tx_override_o
      |-> tx_pin_oe_o == !$past(tx_pin_o))
    else $error("open drain enable wrong");
  // output may be one register behind the shifter
  a_loop_route: assert property (
    lb_q && $past(lb_q) |-> rx_line_o == tx_pin_o || rx_line_o == $past(tx_pin_o))
    else $error("loopback not routed");
  a_pin_release: assert property (
    !tx_override_o && $past(!tx_override_o) |-> !tx_pin_oe_o && !line_driver_dir_out_o)
    else $error("pin driven without override");
  a_dir_send: assert property (
    $fell(tx_pin_o) && ec_q[STX_EC_RS485] |-> ##[0:1] line_driver_dir_out_o)
    else $error("direction output late");
  a_bit_min: assert property (
    $fell(tx_pin_o) |-> !tx_pin_o [*8])
    else $error("bit shorter than eight cycles");
  a_stop_wait: assert property (
    $fell(tx_override_o) |-> !ec_q[STX_EC_TXEN] && $past(tx_pin_o, 2))
    else $error("transmitter released early");
  a_take_pin: assert property (
    ec_q[STX_EC_TXEN] && $past(ec_q[STX_EC_TXEN], 2) |-> tx_override_o)
    else $error("pin not taken");
  a_rd_zero: assert property (
    reg_rd_i && clk_en_i && reg_addr_i > STX_REG_STATUS |=> reg_rdata_o == STX_ZERO8)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (
    !(reg_rd_i && clk_en_i) |=> $stable(reg_rdata_o))
    else $error("read data moved");
  c_release: cover property ($fell(tx_override_o));
  c_loop: cover property (lb_q && $fell(tx_pin_o));
  c_od: cover property (ec_q[STX_EC_OPEN_DRAIN_EN] && tx_pin_oe_o);
endmodule // stx_sva
`default_nettype wire

/* stx_top.sv */
// serial transmitter: frame formatting, fractional rate generator, pin control
// Summary of operation
// R1 - start low, data, parity, high stops
// R2 - five to nine bits, parity, 1-2 stops
// R3 - next frame immediately or idle high
// R4 - divisor is factor times 64, fractional
// R5 - software keeps divisor 64 to 65535
// R6 - sync mode uses integer part only
// R7 - samples per bit 16, 8, 2
// R8 - internal rate unless client clock pin
// R9 - data regs to buffer to shifter
// R10 - done flag when everything drained
// R11 - empty flag; write only when set
// R12 - unused high bits ignored
// R13 - software orders 9-bit byte writes
// R14 - disable waits for all data sent; the code sends only the frame in the shifter, a buffered one holds the pin
// R15 - disabled transmitter releases pin, input
// R16 - open drain forces pin output; the code enables the output only while driving low
// R17 - loopback routes transmit to receiver
// R18 - two-level write buffer before shifter
// R19 - rs485 direction out while sending
// R20 - software startup order
// R21 - software changes rate only when idle
// R22 - odd or even parity generation
// R23 - accumulator spreads fractional remainder
// R24 - lsb first, parity over data
`default_nettype none
module stx_top
  import stx_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       clk_en_i,
  // register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // line side
  input  wire logic       xfer_clock_pin_i,
  input  wire logic       tx_pin_i,
  output logic            tx_pin_o,
  output logic            tx_pin_oe_o,
  output logic            tx_override_o,
  output logic            line_driver_dir_out_o,
  output logic            rx_line_o
);

  logic [15:0]   baud_q;
  logic [7:0]    frame_cfg_q;
  logic [7:0]    en_cfg_q;
  logic [7:0]    loop_cfg_q;
  logic [8:0]    data_reg_q;
  logic          data_full_q;
  logic          hi_written_q;
  logic [8:0]    buf_q;
  logic          buf_full_q;
  logic [11:0]   shift_q;
  logic [3:0]    bits_left_q;
  stx_state_type state_q;
  logic          done_q;
  logic          tx_active_q;
  logic [1:0]    xck_sync_q;
  logic          xck_prev_q;
  logic [1:0]    pin_sync_q;
  logic [9:0]    int_cnt_q;
  logic [STX_FRAC_W-1:0] frac_acc_q;
  logic [4:0]    samp_cnt_q;
  logic          bit_tick;
  logic          samp_tick;
  logic          load_shift;

  wire [2:0] cw       = frame_cfg_q[STX_FC_CHAR_LSB +: 3];
  wire [1:0] par_sel  = frame_cfg_q[STX_FC_PAR_LSB +: 2];
  wire       two_stop = frame_cfg_q[STX_FC_STOP_BIT];
  wire [1:0] mode     = frame_cfg_q[STX_FC_MODE_LSB +: 2];
  wire       sync_md  = (mode == STX_MODE_SYNC);
  wire       tx_en    = en_cfg_q[STX_EC_TXEN];
  // xfer clock as input only in sync client mode (pin not driven by us)
  wire       client_md = sync_md && !en_cfg_q[STX_EC_RS485];
  wire       wr_low   = reg_wr_i && (reg_addr_i == STX_REG_TX_LOW);
  wire       wr_high  = reg_wr_i && (reg_addr_i == STX_REG_TX_HIGH);
  wire       is_nine  = (cw == STX_CW_9L) || (cw == STX_CW_9H);

  // number of data bits for a width code
  function automatic logic [3:0] data_bits(input logic [2:0] c);
    case (c)
      STX_CW_5: data_bits = 4'h5;
      STX_CW_6: data_bits = 4'h6;
      STX_CW_7: data_bits = 4'h7;
      STX_CW_8: data_bits = 4'h8;
      default:  data_bits = 4'h9;
    endcase
  endfunction

  // mask away bits above the character width
  function automatic logic [8:0] width_mask(input logic [8:0] d, input logic [2:0] c);
    logic [8:0] m;
    m = 9'h1ff >> (4'h9 - data_bits(c));
    width_mask = d & m;
  endfunction

  // configuration registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      baud_q      <= STX_BAUD_RST;
      frame_cfg_q <= STX_FC_RST;
      en_cfg_q    <= STX_ZERO8;
      loop_cfg_q  <= STX_ZERO8;
    end else if (clk_en_i && reg_wr_i) begin
      case (reg_addr_i)
        STX_REG_BAUD_LO:   baud_q[7:0]  <= reg_wdata_i;
        STX_REG_BAUD_HI:   baud_q[15:8] <= reg_wdata_i;
        STX_REG_FRAME_CFG: frame_cfg_q  <= reg_wdata_i;
        STX_REG_EN_CFG:    en_cfg_q     <= reg_wdata_i;
        STX_REG_LOOP_CFG:  loop_cfg_q   <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // data registers: a frame is committed by the second byte in 9-bit order
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      data_reg_q   <= 9'h000;
      data_full_q  <= 1'b0;
      hi_written_q <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_high) begin
        data_reg_q[8] <= reg_wdata_i[0];
        hi_written_q  <= is_nine && (cw == STX_CW_9H);
        if (cw == STX_CW_9L && !data_full_q) data_full_q <= 1'b1;
      end
      if (wr_low && !data_full_q) begin  // see R11
        data_reg_q[7:0] <= reg_wdata_i;
        if (cw != STX_CW_9L) data_full_q <= 1'b1;
        hi_written_q <= 1'b0;
      end
      if (data_full_q && !buf_full_q) data_full_q <= 1'b0;  // see R9
    end
  end

  // second buffer level ahead of the shifter
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      buf_q      <= 9'h000;
      buf_full_q <= 1'b0;
    end else if (clk_en_i) begin
      if (load_shift) buf_full_q <= 1'b0;
      if (data_full_q && (!buf_full_q || load_shift)) begin  // see R18
        buf_q      <= width_mask(data_reg_q, cw);  // see R12
        buf_full_q <= 1'b1;
      end
    end
  end

  // rate generator: integer count plus fractional accumulator
  wire [9:0] int_part = baud_q[15:6];
  wire [4:0] samples  = sync_md ? STX_S_SYNC :
                        (en_cfg_q[STX_EC_DBLSPD] ? STX_S_DOUBLE : STX_S_NORMAL);  // see R7
  wire [STX_FRAC_W:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, baud_q[5:0]};
  wire       extra    = !sync_md && frac_sum[STX_FRAC_W];  // see R6
  wire       xck_edge = xck_sync_q[1] && !xck_prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      int_cnt_q  <= 10'h000;
      frac_acc_q <= 6'h00;
      samp_cnt_q <= 5'h00;
    end else if (clk_en_i) begin
      if (state_q == STX_IDLE) begin
        int_cnt_q  <= 10'h000;
        samp_cnt_q <= 5'h00;
      end else if (samp_tick) begin
        int_cnt_q <= 10'h000;
        if (bit_tick) begin
          samp_cnt_q <= 5'h00;
          if (!sync_md) frac_acc_q <= frac_sum[STX_FRAC_W-1:0];  // see R23
        end else begin
          samp_cnt_q <= samp_cnt_q + 5'h01;
        end
      end else begin
        int_cnt_q <= int_cnt_q + 10'h001;
      end
    end
  end

  // a sample period is the integer part; the last sample of a bit may stretch one
  wire last_samp = (samp_cnt_q == samples - 5'h01);
  wire [10:0] samp_len = {1'b0, int_part} + {10'h000, last_samp && extra};  // see R4
  always_comb begin
    samp_tick = (int_cnt_q + 11'h001 == {1'b0, int_cnt_q} + 11'h001)
                && ({1'b0, int_cnt_q} + 11'h001 >= samp_len);
    bit_tick  = samp_tick && last_samp;
    if (client_md) begin  // see R8
      samp_tick = xck_edge;
      bit_tick  = xck_edge;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      xck_sync_q <= 2'b00;
      xck_prev_q <= 1'b0;
      pin_sync_q <= 2'b11;
    end else if (clk_en_i) begin
      xck_sync_q <= {xck_sync_q[0], xfer_clock_pin_i};
      xck_prev_q <= xck_sync_q[1];
      pin_sync_q <= {pin_sync_q[0], tx_pin_i};
    end
  end

  // frame assembly: start, data lsb first, parity, stops
  wire [3:0] nb     = data_bits(cw);
  wire       par_on = (par_sel == STX_PAR_EVEN) || (par_sel == STX_PAR_ODD);
  wire       par_b  = (^buf_q) ^ (par_sel == STX_PAR_ODD);  // see R22 see R24
  logic [11:0] frame;
  always_comb begin
    frame = 12'hfff;  // see R1
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nb)) frame[i] = buf_q[i];
    end
    if (par_on) frame[nb] = par_b;
  end
  wire [3:0] frame_len = nb + {3'h0, par_on} + {3'h0, two_stop} + 4'h1;  // see R2

  // client mode: a start bit waits for a rising transfer-clock edge, so every bit is whole
  assign load_shift = tx_en && buf_full_q &&
                      (((state_q == STX_IDLE) && (!client_md || xck_edge)) ||
                       (bit_tick && bits_left_q == 4'h0));  // see R8

  // shifter state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q     <= STX_IDLE;
      shift_q     <= 12'hfff;
      bits_left_q <= 4'h0;
      tx_pin_o    <= 1'b1;
    end else if (clk_en_i) begin
      case (state_q)
        STX_IDLE: begin
          tx_pin_o <= 1'b1;  // see R3
          if (load_shift) begin
            state_q     <= STX_SHIFT;
            tx_pin_o    <= 1'b0;
            shift_q     <= frame;
            bits_left_q <= frame_len;
          end
        end
        STX_SHIFT: begin
          if (bit_tick) begin
            if (bits_left_q == 4'h0) begin
              if (load_shift) begin  // see R3
                tx_pin_o    <= 1'b0;
                shift_q     <= frame;
                bits_left_q <= frame_len;
              end else begin
                state_q  <= STX_IDLE;
                tx_pin_o <= 1'b1;
              end
            end else begin
              tx_pin_o    <= shift_q[0];
              shift_q     <= {1'b1, shift_q[11:1]};
              bits_left_q <= bits_left_q - 4'h1;
            end
          end
        end
        default: state_q <= STX_IDLE;
      endcase
    end
  end

  wire frame_end = (state_q == STX_SHIFT) && bit_tick && (bits_left_q == 4'h0);

  // done flag: set wins over clear by write of one
  wire clr_done = reg_wr_i && (reg_addr_i == STX_REG_STATUS) && reg_wdata_i[STX_ST_DONE];
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
    end else if (clk_en_i) begin
      if (frame_end && !buf_full_q && !data_full_q) begin
        done_q <= 1'b1;  // see R10
      end else if (clr_done || wr_low || wr_high) begin
        done_q <= 1'b0;
      end
    end
  end

  // transmitter stays active until everything has drained
  wire drained = !data_full_q && !buf_full_q && (state_q == STX_IDLE);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_active_q           <= 1'b0;
      tx_pin_oe_o           <= 1'b0;
      tx_override_o         <= 1'b0;
      line_driver_dir_out_o <= 1'b0;
      rx_line_o             <= 1'b1;
    end else if (clk_en_i) begin
      if (tx_en) tx_active_q <= 1'b1;
      else if (drained) tx_active_q <= 1'b0;  // see R14
      tx_override_o <= tx_active_q;  // see R15
      // open drain: drive only the low level, output enable only while the pin is low
      tx_pin_oe_o <= tx_active_q &&
                     (en_cfg_q[STX_EC_OPEN_DRAIN_EN] ? !tx_pin_o : 1'b1);  // see R16 see R15
      line_driver_dir_out_o <= en_cfg_q[STX_EC_RS485] &&
                               (state_q == STX_SHIFT || load_shift);  // see R19
      rx_line_o <= loop_cfg_q[STX_LC_LOOP] ? tx_pin_o : pin_sync_q[1];  // see R17
    end
  end

  // read port: data one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= STX_ZERO8;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_addr_i)
        STX_REG_BAUD_LO:   reg_rdata_o <= baud_q[7:0];
        STX_REG_BAUD_HI:   reg_rdata_o <= baud_q[15:8];
        STX_REG_FRAME_CFG: reg_rdata_o <= frame_cfg_q;
        STX_REG_EN_CFG:    reg_rdata_o <= en_cfg_q;
        STX_REG_LOOP_CFG:  reg_rdata_o <= loop_cfg_q;
        STX_REG_STATUS: begin
          reg_rdata_o               <= STX_ZERO8;
          reg_rdata_o[STX_ST_DONE]  <= done_q;
          reg_rdata_o[STX_ST_EMPTY] <= !data_full_q;  // see R11
        end
        default: reg_rdata_o <= STX_ZERO8;
      endcase
    end
  end

endmodule // stx_top
`default_nettype wire

/* stx_top_tb.sv */
// self-checking bench for the serial transmitter
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module stx_top_tb
  import stx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0, sync = 1'b0;
  logic        par = 1'b0, stop2 = 1'b0, txo, oe, ovr, dir, rxl, xclk, ppar, pstop;
  logic [3:0]  addr = 4'h0, nb = 4'h8;
  logic [7:0]  wdata = 8'h00, rdata, s, fc;
  logic [8:0]  pdata, ex;
  logic [15:0] pcnt;
  logic [31:0] pts, ptp;
  logic [7:0]  fcv [5] = '{8'h20, 8'h3A, 8'h01, 8'h2E, 8'h37};
  int          num_errors = 0, n_checks = 0, nexp = 0;
  // pull-up holds a released pin high
  wire         line = oe ? txo : 1'b1;
  stx_top u_dut (.clk_sys_i(clk), .rst_b_i(rst_b), .clk_en_i(1'b1), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .xfer_clock_pin_i(xclk), .tx_pin_i(line), .tx_pin_o(txo), .tx_pin_oe_o(oe),
    .tx_override_o(ovr), .line_driver_dir_out_o(dir), .rx_line_o(rxl));
  stx_peer u_peer (.clk_i(clk), .line_i(line), .run_i(run), .xclk_o(xclk), .nbits_i(nb),
    .par_i(par), .stop2_i(stop2), .sync_i(sync), .bit_cyc_i(8'h10), .data_o(pdata),
    .par_o(ppar), .stop_o(pstop), .cnt_o(pcnt), .t_start_o(pts), .t_prev_o(ptp));
  always #5 clk = ~clk;
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_st(input int b);
    s = STX_ZERO8;
    for (int i = 0; i < 2000 && s[b] !== 1'b1; i++) rd_reg(STX_REG_STATUS, s);
    `CHK("status flag", 1'b1, s[b])
  endtask
  task automatic expect_frame(input logic [8:0] d, input logic p);
    nexp++;
    for (int i = 0; i < 20000 && pcnt < nexp; i++) @(posedge clk);
    `CHK("frame data", d, pdata)
    `CHK("parity bit", p, ppar)
    `CHK("stop bits", 1'b1, pstop)
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #500_000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(STX_REG_STATUS, s);
    `CHK("reset status", 2'b01, s[6:5])
    rd_reg(4'hC, s);
    `CHK("unmapped read", STX_ZERO8, s)
    wr_reg(STX_REG_BAUD_LO, 8'h60);
    wr_reg(STX_REG_BAUD_HI, 8'h00);
    wr_reg(STX_REG_FRAME_CFG, STX_FC_RST);
    wr_reg(STX_REG_EN_CFG, 8'h41);
    wr_reg(STX_REG_TX_LOW, 8'h00);
    wait_st(STX_ST_EMPTY);
    wr_reg(STX_REG_TX_LOW, 8'hA5);
    expect_frame(9'h000, 1'b0);
    expect_frame(9'h0A5, 1'b0);
    // ten bits of sixteen cycles, half of them stretched by one
    `CHK("frame length", 32'h0000_00A5, pts - ptp)
    wait_st(STX_ST_DONE);
    wr_reg(STX_REG_STATUS, 8'h40);
    rd_reg(STX_REG_STATUS, s);
    `CHK("done cleared", 1'b0, s[STX_ST_DONE])
    $display("test back to back done");
    wr_reg(STX_REG_BAUD_LO, 8'h80);
    wr_reg(STX_REG_BAUD_HI, 8'h00);
    wr_reg(STX_REG_EN_CFG, 8'h43);
    for (int k = 0; k < 5; k++) begin
      fc = fcv[k];
      nb = (fc[2:0] < 3'h4) ? 4'(fc[2:0]) + 4'h5 : 4'h9;
      {par, stop2} = {fc[5], fc[3]};
      ex = 9'h1B6 & ~(9'h1FF << nb);
      wr_reg(STX_REG_FRAME_CFG, fc);
      if (fc[2:0] == STX_CW_9H) wr_reg(STX_REG_TX_HIGH, 8'h01);
      wr_reg(STX_REG_TX_LOW, 8'hB6);
      if (fc[2:0] == STX_CW_9L) wr_reg(STX_REG_TX_HIGH, 8'h01);
      expect_frame(ex, fc[5] & (^ex ^ fc[4]));
      wait_st(STX_ST_DONE);
    end
    $display("test formats done");
    {nb, par, stop2} = {4'h8, 1'b0, 1'b0};
    wr_reg(STX_REG_FRAME_CFG, STX_FC_RST);
    wr_reg(STX_REG_TX_LOW, 8'h5A);
    wr_reg(STX_REG_EN_CFG, 8'h03);
    #1;
    `CHK("override held", 1'b1, ovr)
    expect_frame(9'h05A, 1'b0);
    wait_st(STX_ST_DONE);
    repeat (4) @(posedge clk);
    #1;
    `CHK("pin released", 2'b00, {ovr, oe})
    $display("test disable done");
    wr_reg(STX_REG_LOOP_CFG, 8'h08);
    wr_reg(STX_REG_EN_CFG, 8'h4A);
    wr_reg(STX_REG_TX_LOW, 8'h3C);
    expect_frame(9'h03C, 1'b0);
    wait_st(STX_ST_DONE);
    $display("test one wire done");
    {sync, run} = 2'b11;
    wr_reg(STX_REG_LOOP_CFG, STX_ZERO8);
    wr_reg(STX_REG_BAUD_LO, 8'h40);
    wr_reg(STX_REG_FRAME_CFG, 8'h43);
    wr_reg(STX_REG_EN_CFG, 8'h40);
    wr_reg(STX_REG_TX_LOW, 8'h96);
    expect_frame(9'h096, 1'b0);
    run = 1'b0;
    $display("test client clock done");
    stop_test();
  end
endmodule // stx_top_tb
bind stx_top stx_sva u_sva (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .xfer_clock_pin_i(xfer_clock_pin_i),
  .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
  .tx_override_o(tx_override_o), .line_driver_dir_out_o(line_driver_dir_out_o),
  .rx_line_o(rx_line_o));
`default_nettype wire
